// *** hw/backlight_pkg.sv ***
package backlight_pkg;
  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_FAULT = 8'h01;
  localparam logic [7:0] REG_IRQ_EN = 8'h02;
  localparam logic [7:0] REG_BRT_LO = 8'h03;
  localparam logic [7:0] REG_BRT_HI = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h10;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] CMD_MASK = 8'h07;
  localparam logic [7:0] FLAG_MASK = 8'hDF;
  localparam logic [7:0] CFG_MASK = 8'hEF;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam int ON_BIT = 0;
  localparam int FLT_OPEN = 7;
  localparam int FLT_OV = 6;
  localparam int FLT_BUV = 4;
  localparam int FLT_OVP = 3;
  localparam int FLT_SUST = 2;
  localparam int FLT_TSD = 1;
  localparam int FLT_SUPPLY_LOCKOUT_FLAG = 0;
  localparam int CFG_STANDBY = 7;
  localparam int CFG_FILT = 6;
  localparam int CFG_ANTI = 5;
  localparam int CFG_RELOAD = 3;
  localparam int CFG_AUTO = 2;
  localparam int CFG_MODE_LSB = 0;
  localparam int LVL_W = 12;
  localparam int TIMER_W = 24;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2C;
  localparam int CLK_HZ = 50_000_000;
  localparam int STANDBY_MS = 50;
  localparam int SUSTAIN_MS = 50;
  localparam int GLITCH_NS = 50;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int STANDBY_CYC = STANDBY_MS * CYC_PER_MS;
  localparam int SUSTAIN_CYC = SUSTAIN_MS * CYC_PER_MS;
  localparam int GLITCH_CYC = (GLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  typedef enum logic [1:0] {
    MODE_PWM = 2'h0,
    MODE_REG = 2'h1,
    MODE_PWM_X_REG = 2'h2,
    MODE_REG_X_PWM = 2'h3
  } mode_t;
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ADDR = 9'h002,
    S_AACK = 9'h004,
    S_PTR = 9'h008,
    S_PACK = 9'h010,
    S_WR = 9'h020,
    S_WACK = 9'h040,
    S_RD = 9'h080,
    S_RACK = 9'h100
  } link_state_t;
endpackage

// *** hw/pwm_link_if.sv ***
`timescale 1ns/1ns
interface pwm_link_if;
  import backlight_pkg::*;
  logic filt_en;
  logic level;
  logic rise;
  logic low_timeout;
  logic [LVL_W-1:0] duty;
  modport cond (input filt_en, output level, output rise, output low_timeout, output duty);
  modport core (output filt_en, input level, input rise, input low_timeout, input duty);
endinterface

// *** hw/pwm_conditioner.sv ***
`timescale 1ns/1ns
module pwm_conditioner import backlight_pkg::*; #(
  parameter int STANDBY_CYCLES = STANDBY_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pwm_pin,
  pwm_link_if.cond pl
);
  logic in_m_q, in_s_q, filt_q, filt_d, prev_q;
  logic [3:0] gcnt_q, gcnt_d;
  logic [TIMER_W-1:0] low_q, low_d;
  logic [LVL_W-1:0] win_q, win_d, duty_q, duty_d;
  logic [LVL_W:0] hi_q, hi_d, hi_sum;

  always_comb begin
    filt_d = filt_q;
    gcnt_d = '0;
    if (!pl.filt_en) begin
      filt_d = in_s_q; // see (RL14)
    end else if (in_s_q != filt_q) begin
      gcnt_d = gcnt_q + 4'h1;
      if (gcnt_q == 4'(GLITCH_CYC - 1)) begin
        filt_d = in_s_q; // see (RL14)
        gcnt_d = '0;
      end
    end
    low_d = filt_q ? '0 : low_q;
    if (!filt_q && low_q != TIMER_W'(STANDBY_CYCLES)) begin
      low_d = low_q + 1'b1;
    end
    hi_sum = hi_q + {{LVL_W{1'b0}}, filt_q};
    win_d = win_q + 1'b1;
    hi_d = hi_sum;
    duty_d = duty_q;
    if (&win_q) begin
      duty_d = hi_sum[LVL_W] ? '1 : hi_sum[LVL_W-1:0];
      hi_d = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_m_q <= 1'b0;
      in_s_q <= 1'b0;
      filt_q <= 1'b0;
      prev_q <= 1'b0;
      gcnt_q <= '0;
      low_q <= '0;
      win_q <= '0;
      hi_q <= '0;
      duty_q <= '0;
    end else begin
      in_m_q <= pwm_pin;
      in_s_q <= in_m_q;
      filt_q <= filt_d;
      prev_q <= filt_q;
      gcnt_q <= gcnt_d;
      low_q <= low_d;
      win_q <= win_d;
      hi_q <= hi_d;
      duty_q <= duty_d;
    end
  end

  assign pl.level = filt_q;
  assign pl.rise = filt_q & ~prev_q;
  assign pl.low_timeout = (low_q == TIMER_W'(STANDBY_CYCLES));
  assign pl.duty = duty_q;
endmodule // pwm_conditioner

// *** hw/backlight_regs.sv ***
// Function
// (RL1) fault flags latch on their condition and hold until the status register is read
// (RL2) bit 7 open/short string flag; kills backlight when auto string bit is 0
// (RL3) string over-voltage bit 6, boost under-voltage bit 4, boost OVP at max request bit 3
// (RL4) bit 2 set when boost under-voltage lasts over 50 ms with backlight on
// (RL5) thermal shutdown sets bit 1 and forces backlight off
// (RL6) supply lockout sets bit 0 and forces backlight off
// (RL7) enable register mirrors flags; interrupt only when flag and enable both set
// (RL8) low brightness register bits 7:4 hold level bits 3:0; bits 3:0 read zero
// (RL9) high brightness register holds level bits 11:4
// (RL10) active level loads only on high byte write
// (RL11) without prior low write, low nibble copies high byte upper nibble
// (RL12) pwm source with standby bit: backlight off after pwm low 50 ms
// (RL13) pwm activity after standby turns the backlight back on
// (RL14) filter bit set rejects pwm pulses under 50 ns; clear passes input
// (RL15) antiphase bit shifts the two boost switchers 180 degrees
// (RL16) reload bit reloads defaults at each turn-on; else only at power-up
// (RL17) auto bit removes faulty strings and re-adds them; else enable field only
// (RL18) source bits 1:0; 00 means pwm duty alone sets brightness
// (RL19) source 01 uses registers, ramping from 0% at each turn-on
// (RL20) source 10 smooths pwm duty and multiplies by register level
// (RL21) source 11 smooths register level and multiplies by pwm duty
// (RL22) command, enable, brightness writable anytime; others only while on bit low
// (RL23) status read clears only visible flags; later or persisting faults set again
`timescale 1ns/1ns
module backlight_regs import backlight_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
  parameter int STANDBY_CYCLES = STANDBY_CYC,
  parameter int SUSTAIN_CYCLES = SUSTAIN_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic pwm_pin,
  input wire logic string_open_short,
  input wire logic string_overvoltage,
  input wire logic boost_undervoltage,
  input wire logic boost_overvoltage,
  input wire logic boost_vmax_requested,
  input wire logic thermal_shutdown,
  input wire logic supply_lockout,
  output logic irq,
  output logic backlight_on,
  output logic low_power,
  output logic [LVL_W-1:0] brightness_out,
  output logic boost_antiphase,
  output logic auto_string_config,
  output logic nvm_reload
);
  pwm_link_if pl ();

  pwm_conditioner #(.STANDBY_CYCLES(STANDBY_CYCLES)) u_pwm (
    .clk(clk),
    .rst_n(rst_n),
    .pwm_pin(pwm_pin),
    .pl(pl)
  );

  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic [7:0] ev_m_q, ev_s_q;
  link_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, rd_data;
  logic [3:0] cnt_q, cnt_d;
  logic rw_q, rw_d, oe_q, oe_d, nack_q, nack_d;
  logic wr_en, rd_load;
  logic [7:0] cmd_q, cmd_d, flags_q, flags_d, irqen_q, irqen_d, cfg_q, cfg_d;
  logic [7:0] hi_q, hi_d, fault_vec, clr_mask;
  logic [3:0] lo_q, lo_d;
  logic lo_pend_q, lo_pend_d;
  logic [LVL_W-1:0] level_q, level_d, smooth_q, smooth_d, target, bright_d;
  logic [2*LVL_W-1:0] product;
  logic [TIMER_W-1:0] sust_q, sust_d;
  logic kill_q, kill_d, stby_q, stby_d, on_prev_q, boot_q, reload_q, reload_d, irq_q, irq_d;
  logic scl_rise, scl_fall, start_c, stop_c, on_active, stby_mode;
  mode_t mode;

  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_c = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign mode = mode_t'(cfg_q[CFG_MODE_LSB +: 2]);
  assign on_active = cmd_q[ON_BIT] & ~kill_q & ~stby_q;
  assign stby_mode = (mode == MODE_PWM) & cfg_q[CFG_STANDBY];

  always_comb begin
    case (ptr_q)
      REG_COMMAND: rd_data = cmd_q;
      REG_FAULT: rd_data = flags_q;
      REG_IRQ_EN: rd_data = irqen_q;
      REG_BRT_LO: rd_data = {lo_q, NIBBLE_ZERO}; // see (RL8)
      REG_BRT_HI: rd_data = hi_q; // see (RL9)
      REG_CONFIG: rd_data = cfg_q;
      default: rd_data = RESET_VAL;
    endcase
  end

  // serial link slave
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    oe_d = oe_q;
    nack_d = nack_q;
    wr_en = 1'b0;
    rd_load = 1'b0;
    if (start_c) begin
      st_d = S_ADDR;
      cnt_d = '0;
      oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = S_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        S_ADDR, S_PTR, S_WR: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BYTE_BITS) begin
            cnt_d = '0;
            oe_d = 1'b1;
            if (st_q == S_ADDR) begin
              rw_d = sh_q[0];
              st_d = S_AACK;
              if (sh_q[7:1] != DEV_ADDR) begin
                st_d = S_IDLE;
                oe_d = 1'b0;
              end
            end else if (st_q == S_PTR) begin
              ptr_d = sh_q;
              st_d = S_PACK;
            end else begin
              wr_en = 1'b1;
              ptr_d = ptr_q + 8'h01;
              st_d = S_WACK;
            end
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            st_d = S_PTR;
            if (rw_q) begin
              rd_load = 1'b1;
            end
          end
        end
        S_PACK, S_WACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            st_d = S_WR;
          end
        end
        S_RD: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == BYTE_BITS) begin
              st_d = S_RACK;
              oe_d = 1'b0;
              cnt_d = '0;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            nack_d = sda_s_q;
          end else if (scl_fall) begin
            st_d = S_IDLE;
            if (!nack_q) begin
              rd_load = 1'b1;
            end
          end
        end
        S_IDLE: st_d = S_IDLE;
        default: st_d = S_IDLE;
      endcase
      if (rd_load) begin
        st_d = S_RD;
        sh_d = rd_data;
        oe_d = ~rd_data[7];
        cnt_d = '0;
        ptr_d = ptr_q + 8'h01;
      end
    end
  end

  // registers, faults and brightness
  always_comb begin
    cmd_d = cmd_q;
    irqen_d = irqen_q;
    cfg_d = cfg_q;
    hi_d = hi_q;
    lo_d = lo_q;
    lo_pend_d = lo_pend_q;
    level_d = level_q;
    kill_d = kill_q;
    if (wr_en) begin
      case (ptr_q)
        REG_COMMAND: begin
          cmd_d = sh_q & CMD_MASK;
          if (!sh_q[ON_BIT]) begin
            kill_d = 1'b0;
          end
        end
        REG_IRQ_EN: irqen_d = sh_q & FLAG_MASK; // see (RL7)
        REG_BRT_LO: begin
          lo_d = sh_q[7:4]; // see (RL8)
          lo_pend_d = 1'b1;
        end
        REG_BRT_HI: begin
          hi_d = sh_q; // see (RL9)
          level_d = {sh_q, lo_pend_q ? lo_q : sh_q[7:4]}; // see (RL10) see (RL11)
          lo_pend_d = 1'b0;
        end
        REG_CONFIG: begin
          if (!cmd_q[ON_BIT]) begin
            cfg_d = sh_q & CFG_MASK; // see (RL22)
          end
        end
        default: cfg_d = cfg_q;
      endcase
    end
    sust_d = '0;
    if (ev_s_q[FLT_BUV] && on_active) begin
      sust_d = (sust_q == TIMER_W'(SUSTAIN_CYCLES)) ? sust_q : sust_q + 1'b1; // see (RL4)
    end
    fault_vec = '0;
    fault_vec[FLT_OPEN] = ev_s_q[FLT_OPEN]; // see (RL2)
    fault_vec[FLT_OV] = ev_s_q[FLT_OV]; // see (RL3)
    fault_vec[FLT_BUV] = ev_s_q[FLT_BUV]; // see (RL3)
    fault_vec[FLT_OVP] = ev_s_q[FLT_OVP] & ev_s_q[5]; // see (RL3)
    fault_vec[FLT_SUST] = (sust_q == TIMER_W'(SUSTAIN_CYCLES)); // see (RL4)
    fault_vec[FLT_TSD] = ev_s_q[FLT_TSD]; // see (RL5)
    fault_vec[FLT_SUPPLY_LOCKOUT_FLAG] = ev_s_q[FLT_SUPPLY_LOCKOUT_FLAG]; // see (RL6)
    clr_mask = (rd_load && ptr_q == REG_FAULT) ? flags_q : RESET_VAL; // see (RL23)
    flags_d = (flags_q & ~clr_mask) | fault_vec; // see (RL1) see (RL23)
    if (fault_vec[FLT_TSD] || fault_vec[FLT_SUPPLY_LOCKOUT_FLAG] || (fault_vec[FLT_OPEN] && !cfg_q[CFG_AUTO])) begin
      kill_d = 1'b1; // see (RL2) see (RL5) see (RL6)
    end
    irq_d = |(flags_d & irqen_d); // see (RL7)
    stby_d = stby_q;
    if (!stby_mode || pl.rise) begin
      stby_d = 1'b0; // see (RL13)
    end else if (cmd_q[ON_BIT] && pl.low_timeout) begin
      stby_d = 1'b1; // see (RL12)
    end
    reload_d = boot_q | (on_active & ~on_prev_q & cfg_q[CFG_RELOAD]); // see (RL16)
    target = (mode == MODE_PWM_X_REG) ? pl.duty : level_q;
    smooth_d = smooth_q;
    if (!on_active) begin
      smooth_d = '0; // see (RL19)
    end else if (smooth_q < target) begin
      smooth_d = smooth_q + 1'b1;
    end else if (smooth_q > target) begin
      smooth_d = smooth_q - 1'b1;
    end
    product = '0;
    case (mode)
      MODE_PWM: bright_d = pl.duty; // see (RL18)
      MODE_REG: bright_d = smooth_q; // see (RL19)
      MODE_PWM_X_REG: begin
        product = smooth_q * level_q; // see (RL20)
        bright_d = product[2*LVL_W-1:LVL_W];
      end
      MODE_REG_X_PWM: begin
        product = smooth_q * pl.duty; // see (RL21)
        bright_d = product[2*LVL_W-1:LVL_W];
      end
      default: bright_d = '0;
    endcase
    if (!on_active) begin
      bright_d = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      ev_m_q <= '0;
      ev_s_q <= '0;
      st_q <= S_IDLE;
      sh_q <= RESET_VAL;
      cnt_q <= '0;
      ptr_q <= RESET_VAL;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      scl_m_q <= scl_pin;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      ev_m_q <= {string_open_short, string_overvoltage, boost_vmax_requested, boost_undervoltage,
                 boost_overvoltage, 1'b0, thermal_shutdown, supply_lockout};
      ev_s_q <= ev_m_q;
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      oe_q <= oe_d;
      nack_q <= nack_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= RESET_VAL;
      flags_q <= RESET_VAL;
      irqen_q <= RESET_VAL;
      cfg_q <= RESET_VAL;
      hi_q <= RESET_VAL;
      lo_q <= NIBBLE_ZERO;
      lo_pend_q <= 1'b0;
      level_q <= '0;
      smooth_q <= '0;
      brightness_out <= '0;
      sust_q <= '0;
      kill_q <= 1'b0;
      stby_q <= 1'b0;
      on_prev_q <= 1'b0;
      boot_q <= 1'b1;
      reload_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      flags_q <= flags_d;
      irqen_q <= irqen_d;
      cfg_q <= cfg_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      lo_pend_q <= lo_pend_d;
      level_q <= level_d;
      smooth_q <= smooth_d;
      brightness_out <= bright_d;
      sust_q <= sust_d;
      kill_q <= kill_d;
      stby_q <= stby_d;
      on_prev_q <= on_active;
      boot_q <= 1'b0;
      reload_q <= reload_d;
      irq_q <= irq_d;
    end
  end

  assign pl.filt_en = cfg_q[CFG_FILT]; // see (RL14)
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign irq = irq_q;
  assign backlight_on = on_prev_q;
  assign low_power = stby_q; // see (RL12)
  assign boost_antiphase = cfg_q[CFG_ANTI]; // see (RL15)
  assign auto_string_config = cfg_q[CFG_AUTO]; // see (RL17)
  assign nvm_reload = reload_q;
endmodule // backlight_regs

// *** tb/i2c_host_model.sv ***
`timescale 1ns/1ns
module i2c_host_model import backlight_pkg::*; #(
  parameter logic [6:0] ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic pull_low
);
  logic [6:0] addr;
  // link clock stands high and the line is released between frames
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
    addr = ADDR;
  end
  task automatic q(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic put(input logic b);
    pull_low = ~b;
    q(3);
    scl = 1'b1;
    q(4);
    scl = 1'b0;
    q(1);
  endtask
  task automatic get(output logic b);
    pull_low = 1'b0;
    q(3);
    scl = 1'b1;
    q(4);
    b = sda;
    scl = 1'b0;
    q(1);
  endtask
  task automatic start();
    pull_low = 1'b0;
    q(6);
    scl = 1'b1;
    q(4);
    pull_low = 1'b1;
    q(4);
    scl = 1'b0;
    q(1);
  endtask
  task automatic stop();
    pull_low = 1'b1;
    q(3);
    scl = 1'b1;
    q(4);
    pull_low = 1'b0;
    q(4);
  endtask
  task automatic send(input logic [7:0] d, output logic nak);
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(nak);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic nak);
    logic n1, n2, n3;
    start();
    send({addr, 1'b0}, n1);
    send(p, n2);
    send(d, n3);
    stop();
    nak = n1 | n2 | n3;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic nak);
    logic n1, n2, n3;
    start();
    send({addr, 1'b0}, n1);
    send(p, n2);
    start();
    send({addr, 1'b1}, n3);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    stop();
    nak = n1 | n2 | n3;
  endtask
endmodule // i2c_host_model

// *** tb/backlight_regs_props.sv ***
`timescale 1ns/1ns
module backlight_regs_props import backlight_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic pwm_pin,
  input wire logic string_open_short,
  input wire logic thermal_shutdown,
  input wire logic supply_lockout,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic irq,
  input wire logic backlight_on,
  input wire logic low_power,
  input wire logic [LVL_W-1:0] brightness_out,
  input wire logic boost_antiphase,
  input wire logic auto_string_config,
  input wire logic nvm_reload
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic scl_prev_q, scl_prev_d;
  logic [3:0] fall_cnt_q, fall_cnt_d;
  // cycles since the last falling edge of the link clock
  always_comb begin
    scl_prev_d = scl_pin;
    fall_cnt_d = (scl_prev_q && !scl_pin) ? 4'h0 : ((fall_cnt_q == 4'hF) ? fall_cnt_q : fall_cnt_q + 4'h1);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_q <= 1'b1;
      fall_cnt_q <= 4'hF;
    end else begin
      scl_prev_q <= scl_prev_d;
      fall_cnt_q <= fall_cnt_d;
    end
  end
  sda_low_a: assert property (sda_out == 1'b0) else $error("sda driven high");
  ack_timing_a: assert property ($changed(sda_oe) |-> fall_cnt_q inside {[4'h1:4'h8]})
    else $error("sda enable moved away from clock fall");
  therm_off_a: assert property (thermal_shutdown [*3] |-> ##[0:6] !backlight_on)
    else $error("thermal fault left backlight on");
  lockout_off_a: assert property (supply_lockout [*3] |-> ##[0:6] !backlight_on)
    else $error("lockout left backlight on");
  open_off_a: assert property (string_open_short [*3] ##0 !auto_string_config |-> ##[0:6] !backlight_on)
    else $error("open string left backlight on");
  off_dark_a: assert property (!backlight_on [*3] |-> brightness_out == '0)
    else $error("brightness while off");
  standby_off_a: assert property (low_power [*2] |-> !backlight_on) else $error("standby with backlight on");
  standby_pwm_a: assert property ($rose(low_power) |-> !pwm_pin && !$past(pwm_pin, 4))
    else $error("standby entered with pwm active");
  cfg_hold_a: assert property ($changed(boost_antiphase) || $changed(auto_string_config) |-> !$past(backlight_on))
    else $error("config changed while on");
  reload_pulse_a: assert property (nvm_reload |=> !nvm_reload) else $error("reload pulse too long");
  cover property ($rose(low_power));
  cover property ($rose(irq));
  cover property (nvm_reload ##[1:4] backlight_on);
endmodule // backlight_regs_props
bind backlight_regs backlight_regs_props chk (.clk(clk), .rst_n(rst_n), .scl_pin(scl_pin), .pwm_pin(pwm_pin),
  .string_open_short(string_open_short), .thermal_shutdown(thermal_shutdown), .supply_lockout(supply_lockout),
  .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq), .backlight_on(backlight_on), .low_power(low_power),
  .brightness_out(brightness_out), .boost_antiphase(boost_antiphase), .auto_string_config(auto_string_config),
  .nvm_reload(nvm_reload));

// *** tb/backlight_regs_tb_top.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module backlight_regs_tb_top import backlight_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, pwm_pin = 1'b0, vmax = 1'b1, nak, scl, pull_low, sda_out, sda_oe, irq;
  logic backlight_on, low_power, boost_antiphase, auto_string_config, nvm_reload;
  logic [7:0] flt = 8'h00, rdat, lo, hi;
  logic [3:0] pcnt = 4'h0;
  logic [4:0] pwm_h = 5'h00;
  logic [LVL_W-1:0] brightness_out;
  logic [31:0] lfsr = 32'h69466916;
  int n_mismatch = 0, num_checks = 0, cyc = 0, n_reload = 0, r0;
  int fbits [6] = '{7, 6, 4, 3, 1, 0};
  logic [16:0] rows [6] = '{{1'b1, 8'h95, 8'hFC}, {1'b1, 8'h10, 8'hDC}, {1'b0, 8'h00, 8'h8C},
    {1'b0, 8'h00, 8'h0C}, {1'b0, 8'h00, 8'h00}, {1'b0, 8'h00, 8'hFF}};
  wire sda = ~(pull_low | sda_oe);
  i2c_host_model #(.ADDR(DEV_ADDR_DEFAULT)) host (.clk(clk), .sda(sda), .scl(scl), .pull_low(pull_low));
  backlight_regs #(.DEV_ADDR(DEV_ADDR_DEFAULT), .STANDBY_CYCLES(50), .SUSTAIN_CYCLES(50)) uut (.clk(clk),
    .rst_n(rst_n), .scl_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .pwm_pin(pwm_pin),
    .string_open_short(flt[7]), .string_overvoltage(flt[6]), .boost_undervoltage(flt[4]),
    .boost_overvoltage(flt[3]), .boost_vmax_requested(vmax), .thermal_shutdown(flt[1]),
    .supply_lockout(flt[0]), .irq(irq), .backlight_on(backlight_on), .low_power(low_power),
    .brightness_out(brightness_out), .boost_antiphase(boost_antiphase),
    .auto_string_config(auto_string_config), .nvm_reload(nvm_reload));
  always #10 clk = ~clk;
  always @(negedge clk) begin
    pcnt = pcnt + 4'h1;
    pwm_pin = ({1'b0, pcnt} < pwm_h);
    if (nvm_reload === 1'b1) n_reload++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      n_mismatch++;
      complete_run();
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] mix(input logic [11:0] a, input logic [11:0] b);
    return 12'(({12'h000, a} * {12'h000, b}) >> 12);
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.wr(p, d, nak);
    `CHK(nak, 1'b0)
  endtask
  task automatic rd(input logic [7:0] p);
    host.rd(p, rdat, nak);
    `CHK(nak, 1'b0)
  endtask
  task automatic wait_lvl(input logic [11:0] e);
    for (int k = 0; k < 5000 && brightness_out !== e; k++) @(negedge clk);
  endtask
  task automatic run_mode(input logic [7:0] cfg, input logic [4:0] h, input logic [11:0] e);
    pwm_h = h;
    wr(REG_COMMAND, 8'h00);
    wr(REG_CONFIG, cfg);
    r0 = n_reload;
    wr(REG_COMMAND, 8'h01);
    rd(REG_CONFIG);
    `CHK(rdat, cfg & CFG_MASK)
    `CHK(n_reload - r0, int'(cfg[CFG_RELOAD]))
    `CHK(boost_antiphase, cfg[CFG_ANTI])
    `CHK(auto_string_config, cfg[CFG_AUTO])
    repeat (4200) @(negedge clk);
    wait_lvl(e);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    wr(8'h20, 8'h5A);
    foreach (fbits[j]) begin
      rd({REG_FAULT, REG_IRQ_EN, REG_BRT_LO, REG_BRT_HI, REG_CONFIG, 8'h20} >> (8 * j));
      `CHK(rdat, RESET_VAL)
    end
    host.addr = DEV_ADDR_DEFAULT ^ 7'h01;
    host.wr(REG_CONFIG, 8'h01, nak);
    `CHK(nak, 1'b1)
    host.addr = DEV_ADDR_DEFAULT;
    $display("test reset values done");
    wr(REG_CONFIG, 8'h01);
    wr(REG_BRT_HI, 8'h80);
    wr(REG_COMMAND, 8'h01);
    `CHK(brightness_out < 12'h100, 1'b1)
    for (int i = 0; i < 9; i++) begin
      lfsr = nxt(lfsr);
      lo = (i < 3) ? lfsr[7:0] : rows[i - 3][15:8];
      hi = (i < 3) ? lfsr[15:8] : rows[i - 3][7:0];
      if (i < 3 || rows[i - 3][16]) wr(REG_BRT_LO, lo);
      wr(REG_BRT_HI, hi);
      wait_lvl({hi, (i < 3 || rows[i - 3][16]) ? lo[7:4] : hi[7:4]});
      `CHK(brightness_out, {hi, (i < 3 || rows[i - 3][16]) ? lo[7:4] : hi[7:4]})
    end
    wr(REG_BRT_LO, 8'h3C);
    repeat (200) @(negedge clk);
    `CHK(brightness_out, 12'hFFF)
    rd(REG_BRT_LO);
    `CHK(rdat, 8'h30)
    wr(REG_CONFIG, 8'hFF);
    rd(REG_CONFIG);
    `CHK(rdat, 8'h01)
    $display("test brightness done");
    foreach (fbits[j]) begin
      lfsr = nxt(lfsr);
      wr(REG_IRQ_EN, lfsr[7:0]);
      flt[fbits[j]] = 1'b1;
      repeat (8) @(negedge clk);
      flt[fbits[j]] = 1'b0;
      repeat (6) @(negedge clk);
      `CHK(irq, lfsr[fbits[j]])
      `CHK(backlight_on, 1'(!(fbits[j] inside {7, 1, 0})))
      rd(REG_FAULT);
      `CHK(rdat, 8'h01 << fbits[j])
      rd(REG_FAULT);
      `CHK(rdat, 8'h00)
      `CHK(irq, 1'b0)
      wr(REG_COMMAND, 8'h00);
      wr(REG_COMMAND, 8'h01);
    end
    vmax = 1'b0;
    flt[3] = 1'b1;
    repeat (8) @(negedge clk);
    flt[3] = 1'b0;
    rd(REG_FAULT);
    `CHK(rdat, 8'h00)
    flt[4] = 1'b1;
    repeat (80) @(negedge clk);
    rd(REG_FAULT);
    `CHK(rdat, 8'h14)
    rd(REG_FAULT);
    `CHK(rdat, 8'h14)
    flt[4] = 1'b0;
    rd(REG_FAULT);
    rd(REG_FAULT);
    `CHK(rdat, 8'h00)
    $display("test faults done");
    run_mode(8'h2C, 5'd8, 12'h800);
    `CHK(brightness_out, 12'h800)
    run_mode(8'h2E, 5'd8, mix(12'h800, 12'hFFF));
    `CHK(brightness_out, mix(12'h800, 12'hFFF))
    run_mode(8'h2F, 5'd8, mix(12'hFFF, 12'h800));
    `CHK(brightness_out, mix(12'hFFF, 12'h800))
    run_mode(8'h40, 5'd1, 12'h000);
    `CHK(brightness_out, 12'h000)
    run_mode(8'h00, 5'd1, 12'h100);
    `CHK(brightness_out, 12'h100)
    $display("test modes done");
    run_mode(8'h80, 5'd8, 12'h800);
    pwm_h = 5'd0;
    repeat (30) @(negedge clk);
    `CHK(low_power, 1'b0)
    repeat (40) @(negedge clk);
    `CHK({low_power, backlight_on}, 2'b10)
    pwm_h = 5'd8;
    repeat (24) @(negedge clk);
    `CHK({low_power, backlight_on}, 2'b01)
    $display("test standby done");
    complete_run();
  end
endmodule // backlight_regs_tb_top
